//--- rtl/rls_limit.v
// Behaviour
// - two independent relays on one level
// - relay energises at switch-on point
// - relay de-energises at switch-off point
// - off below on gives minimum fail-safe
// - off above on gives maximum fail-safe
// - mode 0 standard, 1 acknowledgement
// - acknowledge field write acknowledges relay
// - acknowledgement mode holds attained state
// - return needs acknowledge and switch-back condition
// - fault: 0 de-energise, 1 freeze state
// - integrating defaults 72/38 and 38/72
// - pulse-count defaults 90/10 and 10/90
// - mode write 0 restores default points
// - integrating: band overlap or range warning
// - per-relay limit range warning, integrating
// - per-relay hysteresis too small warning
// - pulse-count hysteresis below 45 warns
// - warn when dose rate too low, integrating only
// - pulse-count factor scales response one-six
// - shared integration setting defaults to 7
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "rls_limit_regs.vh"

module rls_limit #(
   parameter TICK_CYCLES    = `RLS_TICK_NS / `RLS_CLK_NS,
   parameter MIN_RESP_TICKS = 1,
   parameter DOSE_PRODUCT   = 1000
) (
   input  wire        sys_clk,
   input  wire        rst,
   input  wire [5:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire [6:0]  normalised_level_value,
   input  wire [15:0] dose_rate,
   input  wire        self_fault,
   output reg         relay1_out_q,
   output reg         relay2_out_q,
   output reg         warning_q
);

   reg  [31:0] tick_cnt_q;
   reg         tick_q;
   reg  [2:0]  fault_sync_q;
   reg         fault_q;
   reg         pulse_type_q;
   reg  [8:0]  integration_setting;
   reg  [6:0]  relay1_energise_point;
   reg  [6:0]  relay1_deenergise_point;
   reg         relay1_operating_mode;
   reg         relay1_on_fault_setting;
   reg  [6:0]  relay2_energise_point;
   reg  [6:0]  relay2_deenergise_point;
   reg         relay2_operating_mode;
   reg         relay2_on_fault_setting;
   reg         ack1_q;
   reg         ack2_q;
   reg  [6:0]  status_q;
   reg  [31:0] rdata_d;
   reg  [6:0]  band;
   reg  [8:0]  delay_d;
   reg  [8:0]  factor;
   wire        relay1_q;
   wire        relay2_q;
   wire        held1;
   wire        held2;
   wire        bus_req;
   wire        bus_take;
   wire        wr_lo;
   wire        wr_hi;
   wire [6:0]  hys1;
   wire [6:0]  hys2;
   wire [6:0]  min_hys;
   wire        lim1_bad;
   wire        lim2_bad;
   wire [24:0] dose_prod;
   wire        integration_too_short_warning;
   wire [6:0]  def_on1;
   wire [6:0]  def_off1;
   wire [6:0]  def_on2;
   wire [6:0]  def_off2;

   // defaults follow the detector type in use
   assign def_on1  = pulse_type_q ? `RLS_PLS_ON1  : `RLS_INT_ON1;
   assign def_off1 = pulse_type_q ? `RLS_PLS_OFF1 : `RLS_INT_OFF1;
   assign def_on2  = pulse_type_q ? `RLS_PLS_ON2  : `RLS_INT_ON2;
   assign def_off2 = pulse_type_q ? `RLS_PLS_OFF2 : `RLS_INT_OFF2;

   // one-second time base for the integration delay
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q >= TICK_CYCLES - 1) begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
         tick_q     <= 1'b0;
      end
   end

   // fault pin: a change counts once the last two stages agree
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fault_sync_q <= 3'b000;
         fault_q      <= 1'b0;
      end else begin
         fault_sync_q <= {fault_sync_q[1:0], self_fault};
         if (fault_sync_q[1] == fault_sync_q[2])
            fault_q <= fault_sync_q[2];
      end
   end

   // integrating: seconds; pulse-count: factor clamped 1..6
   always @* begin
      factor = integration_setting;
      if (factor < `RLS_FACTOR_MIN)
         factor = `RLS_FACTOR_MIN;
      if (factor > `RLS_FACTOR_MAX)
         factor = `RLS_FACTOR_MAX;
      if (pulse_type_q)
         delay_d = factor * MIN_RESP_TICKS[8:0];
      else
         delay_d = integration_setting;
   end

   // statistical band narrows as the integration time grows
   always @* begin
      if (integration_setting <= 9'h002)
         band = 7'h14;
      else if (integration_setting <= 9'h007)
         band = 7'h0a;
      else if (integration_setting <= 9'h01e)
         band = 7'h05;
      else
         band = 7'h02;
   end

   assign hys1 = (relay1_energise_point > relay1_deenergise_point) ?
                 relay1_energise_point - relay1_deenergise_point :
                 relay1_deenergise_point - relay1_energise_point;
   assign hys2 = (relay2_energise_point > relay2_deenergise_point) ?
                 relay2_energise_point - relay2_deenergise_point :
                 relay2_deenergise_point - relay2_energise_point;
   // overlap of the two bands means hysteresis under twice the band
   assign min_hys = pulse_type_q ? `RLS_PLS_MIN_HYS : {band[5:0], 1'b0};

   // point minus band below 0 or plus band above 100
   assign lim1_bad = !pulse_type_q &&
      ((relay1_energise_point < band) || (relay1_deenergise_point < band) ||
       ({1'b0, relay1_energise_point} + {1'b0, band} > {1'b0, `RLS_LEVEL_MAX}) ||
       ({1'b0, relay1_deenergise_point} + {1'b0, band} > {1'b0, `RLS_LEVEL_MAX}));
   assign lim2_bad = !pulse_type_q &&
      ((relay2_energise_point < band) || (relay2_deenergise_point < band) ||
       ({1'b0, relay2_energise_point} + {1'b0, band} > {1'b0, `RLS_LEVEL_MAX}) ||
       ({1'b0, relay2_deenergise_point} + {1'b0, band} > {1'b0, `RLS_LEVEL_MAX}));

   assign dose_prod = dose_rate * integration_setting;
   assign integration_too_short_warning = !pulse_type_q &&
      (dose_prod < DOSE_PRODUCT[24:0]);

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         status_q     <= 7'h00;
         relay1_out_q <= 1'b0;
         relay2_out_q <= 1'b0;
         warning_q    <= 1'b0;
      end else begin
         status_q[`RLS_ST_R1]    <= relay1_q;
         status_q[`RLS_ST_R2]    <= relay2_q;
         status_q[`RLS_ST_LIM1]  <= lim1_bad;
         status_q[`RLS_ST_LIM2]  <= lim2_bad;
         status_q[`RLS_ST_HYS1]  <= hys1 < min_hys;
         status_q[`RLS_ST_HYS2]  <= hys2 < min_hys;
         status_q[`RLS_ST_SHORT] <= integration_too_short_warning;
         relay1_out_q <= relay1_q;
         relay2_out_q <= relay2_q;
         warning_q    <= |status_q[`RLS_ST_SHORT:`RLS_ST_LIM1];
      end
   end

   // both channels see the same level and settle on their own
   rls_relay_chan u_relay1 (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .level       (normalised_level_value),
      .on_pt       (relay1_energise_point),
      .off_pt      (relay1_deenergise_point),
      .ack_mode    (relay1_operating_mode),
      .fault_hold  (relay1_on_fault_setting),
      .fault       (fault_q),
      .ack_pulse   (ack1_q),
      .tick        (tick_q),
      .delay_ticks (delay_d),
      .relay_q     (relay1_q),
      .held_q      (held1)
   );

   rls_relay_chan u_relay2 (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .level       (normalised_level_value),
      .on_pt       (relay2_energise_point),
      .off_pt      (relay2_deenergise_point),
      .ack_mode    (relay2_operating_mode),
      .fault_hold  (relay2_on_fault_setting),
      .fault       (fault_q),
      .ack_pulse   (ack2_q),
      .tick        (tick_q),
      .delay_ticks (delay_d),
      .relay_q     (relay2_q),
      .held_q      (held2)
   );

   // answer one cycle after the request is seen, then drop back
   assign bus_req  = avs_read ^ avs_write;
   assign bus_take = bus_req && !avs_waitrequest;
   assign wr_lo    = avs_write && bus_take && avs_byteenable[0];
   assign wr_hi    = avs_write && bus_take && avs_byteenable[1];

   always @* begin
      rdata_d = 32'h0000_0000;
      if (avs_address == `RLS_OFF_CTRL)
         rdata_d[`RLS_CTRL_PULSE] = pulse_type_q;
      else if (avs_address == `RLS_OFF_LEVEL)
         rdata_d[6:0] = normalised_level_value;
      else if (avs_address == `RLS_OFF_INTEG)
         rdata_d[8:0] = integration_setting;
      else if (avs_address == `RLS_OFF_R1_ON)
         rdata_d[6:0] = relay1_energise_point;
      else if (avs_address == `RLS_OFF_R1_OFF)
         rdata_d[6:0] = relay1_deenergise_point;
      else if (avs_address == `RLS_OFF_R1_MODE)
         rdata_d[1:0] = {relay1_on_fault_setting, relay1_operating_mode};
      else if (avs_address == `RLS_OFF_R1_ACK)
         rdata_d[0] = held1;
      else if (avs_address == `RLS_OFF_R2_ON)
         rdata_d[6:0] = relay2_energise_point;
      else if (avs_address == `RLS_OFF_R2_OFF)
         rdata_d[6:0] = relay2_deenergise_point;
      else if (avs_address == `RLS_OFF_R2_MODE)
         rdata_d[1:0] = {relay2_on_fault_setting, relay2_operating_mode};
      else if (avs_address == `RLS_OFF_R2_ACK)
         rdata_d[0] = held2;
      else if (avs_address == `RLS_OFF_STATUS)
         rdata_d[7:0] = {fault_q, status_q};
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= !(bus_req && avs_waitrequest);
         if (bus_req && avs_waitrequest && avs_read)
            avs_readdata <= rdata_d;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pulse_type_q            <= 1'b0;
         integration_setting     <= `RLS_INTEG_RST;
         relay1_energise_point   <= `RLS_INT_ON1;
         relay1_deenergise_point <= `RLS_INT_OFF1;
         relay1_operating_mode   <= 1'b0;
         relay1_on_fault_setting <= 1'b0;
         relay2_energise_point   <= `RLS_INT_ON2;
         relay2_deenergise_point <= `RLS_INT_OFF2;
         relay2_operating_mode   <= 1'b0;
         relay2_on_fault_setting <= 1'b0;
         ack1_q                  <= 1'b0;
         ack2_q                  <= 1'b0;
      end else begin
         ack1_q <= wr_lo && (avs_address == `RLS_OFF_R1_ACK);
         ack2_q <= wr_lo && (avs_address == `RLS_OFF_R2_ACK);
         if (wr_lo && avs_address == `RLS_OFF_CTRL) begin
            pulse_type_q <= avs_writedata[`RLS_CTRL_PULSE];
         end else if (avs_address == `RLS_OFF_INTEG) begin
            if (wr_lo)
               integration_setting[7:0] <= avs_writedata[7:0];
            if (wr_hi)
               integration_setting[8] <= avs_writedata[8];
         end else if (wr_lo && avs_address == `RLS_OFF_R1_ON) begin
            relay1_energise_point <= avs_writedata[6:0];
         end else if (wr_lo && avs_address == `RLS_OFF_R1_OFF) begin
            relay1_deenergise_point <= avs_writedata[6:0];
         end else if (wr_lo && avs_address == `RLS_OFF_R1_MODE) begin
            relay1_operating_mode   <= avs_writedata[`RLS_MODE_ACK];
            relay1_on_fault_setting <= avs_writedata[`RLS_MODE_FHOLD];
            if (!avs_writedata[`RLS_MODE_ACK]) begin
               relay1_energise_point   <= def_on1;
               relay1_deenergise_point <= def_off1;
            end
         end else if (wr_lo && avs_address == `RLS_OFF_R2_ON) begin
            relay2_energise_point <= avs_writedata[6:0];
         end else if (wr_lo && avs_address == `RLS_OFF_R2_OFF) begin
            relay2_deenergise_point <= avs_writedata[6:0];
         end else if (wr_lo && avs_address == `RLS_OFF_R2_MODE) begin
            relay2_operating_mode   <= avs_writedata[`RLS_MODE_ACK];
            relay2_on_fault_setting <= avs_writedata[`RLS_MODE_FHOLD];
            if (!avs_writedata[`RLS_MODE_ACK]) begin
               relay2_energise_point   <= def_on2;
               relay2_deenergise_point <= def_off2;
            end
         end
      end
   end

endmodule

//--- shared/rls_limit_regs.vh
`ifndef RLS_LIMIT_REGS_VH
`define RLS_LIMIT_REGS_VH

// register byte offsets
`define RLS_OFF_CTRL      6'h00
`define RLS_OFF_LEVEL     6'h04
`define RLS_OFF_INTEG     6'h08
`define RLS_OFF_R1_ON     6'h0c
`define RLS_OFF_R1_OFF    6'h10
`define RLS_OFF_R1_MODE   6'h14
`define RLS_OFF_R1_ACK    6'h18
`define RLS_OFF_R2_ON     6'h1c
`define RLS_OFF_R2_OFF    6'h20
`define RLS_OFF_R2_MODE   6'h24
`define RLS_OFF_R2_ACK    6'h28
`define RLS_OFF_STATUS    6'h2c

// field positions
`define RLS_CTRL_PULSE    0
`define RLS_MODE_ACK      0
`define RLS_MODE_FHOLD    1
`define RLS_ST_R1         0
`define RLS_ST_R2         1
`define RLS_ST_LIM1       2
`define RLS_ST_LIM2       3
`define RLS_ST_HYS1       4
`define RLS_ST_HYS2       5
`define RLS_ST_SHORT      6
`define RLS_ST_FAULT      7

// reset and default values
`define RLS_INTEG_RST     9'h007
`define RLS_INT_ON1       7'h48
`define RLS_INT_OFF1      7'h26
`define RLS_INT_ON2       7'h26
`define RLS_INT_OFF2      7'h48
`define RLS_PLS_ON1       7'h5a
`define RLS_PLS_OFF1      7'h0a
`define RLS_PLS_ON2       7'h0a
`define RLS_PLS_OFF2      7'h5a
`define RLS_LEVEL_MAX     7'h64
`define RLS_PLS_MIN_HYS   7'h2d
`define RLS_FACTOR_MIN    9'h001
`define RLS_FACTOR_MAX    9'h006

// timing: one integration tick is one second
`define RLS_TICK_NS       1000000000
`define RLS_CLK_NS        20

`endif

//--- rtl/rls_relay_chan.v
`timescale 1ns/1ps
`include "rls_limit_regs.vh"

module rls_relay_chan (
   input  wire       sys_clk,
   input  wire       rst,
   input  wire [6:0] level,
   input  wire [6:0] on_pt,
   input  wire [6:0] off_pt,
   input  wire       ack_mode,
   input  wire       fault_hold,
   input  wire       fault,
   input  wire       ack_pulse,
   input  wire       tick,
   input  wire [8:0] delay_ticks,
   output reg        relay_q,
   output reg        held_q
);

   localparam ST_OFF = 2'b01;
   localparam ST_ON  = 2'b10;

   reg  [1:0] state_q;
   reg        ack_q;
   reg  [8:0] cnt_q;
   wire       min_mode;
   wire       want_on;
   wire       want_off;
   wire       change;
   wire       allowed;
   wire       fire;

   assign min_mode = (off_pt <= on_pt);
   assign want_on  = min_mode ? (level >= on_pt) : (level <= on_pt);
   assign want_off = min_mode ? (level <= off_pt) : (level >= off_pt);
   // between the points neither condition holds, so the state stays
   assign change   = state_q[1] ? want_off : want_on;
   assign allowed  = !held_q || ack_q;
   assign fire     = change && allowed && (cnt_q >= delay_ticks);

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_OFF;
         relay_q <= 1'b0;
         held_q  <= 1'b0;
         ack_q   <= 1'b0;
         cnt_q   <= 9'h000;
      end else if (fault) begin
         cnt_q <= 9'h000;
         if (!fault_hold) begin
            state_q <= ST_OFF;
            relay_q <= 1'b0;
         end
      end else begin
         // the clear on the return wins over an acknowledge arriving in the same cycle
         if (ack_pulse && held_q)
            ack_q <= 1'b1;
         if (!ack_mode) begin
            held_q <= 1'b0;
            ack_q  <= 1'b0;
         end
         if (!(change && allowed))
            cnt_q <= 9'h000;
         else if (!fire && tick)
            cnt_q <= cnt_q + 9'h001;
         if (fire) begin
            cnt_q <= 9'h000;
            case (state_q)
               ST_OFF: begin
                  state_q <= ST_ON;
                  relay_q <= 1'b1;
               end
               default: begin
                  state_q <= ST_OFF;
                  relay_q <= 1'b0;
               end
            endcase
            if (held_q) begin
               held_q <= 1'b0;
               ack_q  <= 1'b0;
            end else if (ack_mode) begin
               held_q <= 1'b1;
            end
         end
      end
   end

endmodule

//--- test/rls_plant_model.sv
`timescale 1ns/1ps

// level source and dose source as same-clock plant logic
module rls_plant_model (
   input  wire        sys_clk,
   input  wire        rst,
   input  wire [6:0]  cmd_level,
   input  wire [15:0] cmd_dose,
   output reg  [6:0]  level_q,
   output reg  [15:0] dose_q
);
   // one level feeds both relay channels
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         level_q <= 7'h32;
         dose_q  <= 16'h00c8;
      end else begin
         // normalised scale tops out at 100
         level_q <= (cmd_level > 7'h64) ? 7'h64 : cmd_level;
         dose_q  <= cmd_dose;
      end
   end
endmodule

//--- test/rls_limit_chk.sv
`timescale 1ns/1ps
`include "rls_limit_regs.vh"

module rls_limit_chk (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic [5:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [6:0]  normalised_level_value,
   input wire logic [15:0] dose_rate,
   input wire logic        self_fault,
   input wire logic        relay1_out_q,
   input wire logic        relay2_out_q,
   input wire logic        warning_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // shadow of the on-fault bits, fault length counter
   logic       fh1_q;
   logic       fh2_q;
   logic [3:0] fcnt_q;
   wire        wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fh1_q  <= 1'b0;
         fh2_q  <= 1'b0;
         fcnt_q <= 4'h0;
      end else begin
         if (wr_ok && avs_address == `RLS_OFF_R1_MODE)
            fh1_q <= avs_writedata[`RLS_MODE_FHOLD];
         if (wr_ok && avs_address == `RLS_OFF_R2_MODE)
            fh2_q <= avs_writedata[`RLS_MODE_FHOLD];
         if (!self_fault)
            fcnt_q <= 4'h0;
         else if (fcnt_q != 4'hf)
            fcnt_q <= fcnt_q + 4'h1;
      end
   end

   sequence s_req;
      (avs_read ^ avs_write) && avs_waitrequest;
   endsequence
   sequence s_ans;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   property p_take;
      s_req |=> s_ans;
   endproperty
   a_take: assert property (p_take) else $error("request not answered in one cycle");
   property p_one;
      $fell(avs_waitrequest) |=> avs_waitrequest;
   endproperty
   a_one: assert property (p_one) else $error("waitrequest low too long");
   property p_refuse;
      avs_read && avs_write |=> avs_waitrequest;
   endproperty
   a_refuse: assert property (p_refuse) else $error("read with write answered");
   property p_cause;
      !avs_waitrequest |-> $past(avs_read ^ avs_write);
   endproperty
   a_cause: assert property (p_cause) else $error("answer without request");
   property p_hold;
      avs_waitrequest || avs_write |-> $stable(avs_readdata);
   endproperty
   a_hold: assert property (p_hold) else $error("readdata moved outside read answer");
   property p_unmap;
      avs_read && !avs_write && avs_waitrequest && avs_address > `RLS_OFF_STATUS
         |=> !avs_waitrequest && avs_readdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_upper;
      !avs_waitrequest && avs_read |-> avs_readdata[31:9] == 23'h0;
   endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_f0;
      fcnt_q >= 4'h7 |-> (fh1_q || !relay1_out_q) && (fh2_q || !relay2_out_q);
   endproperty
   a_f0: assert property (p_f0) else $error("relay energised on fault");
   property p_f1;
      fcnt_q >= 4'h8 |-> (!fh1_q || $stable(relay1_out_q)) && (!fh2_q || $stable(relay2_out_q));
   endproperty
   a_f1: assert property (p_f1) else $error("frozen relay moved on fault");
endmodule

bind rls_limit rls_limit_chk u_chk (
   .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .normalised_level_value(normalised_level_value), .dose_rate(dose_rate),
   .self_fault(self_fault), .relay1_out_q(relay1_out_q), .relay2_out_q(relay2_out_q),
   .warning_q(warning_q)
);

//--- test/rls_limit_test.sv
`timescale 1ns/1ps
`include "rls_limit_regs.vh"

module rls_limit_test;
   localparam TICK = 4;
   reg         sys_clk = 1'b0;
   reg         rst = 1'b1;
   reg  [5:0]  avs_address = 6'h00;
   reg         avs_read = 1'b0;
   reg         avs_write = 1'b0;
   reg  [31:0] avs_writedata = 32'h0;
   reg  [3:0]  avs_byteenable = 4'h0;
   wire [31:0] avs_readdata;
   wire        avs_waitrequest;
   reg  [6:0]  cmd_level = 7'h32;
   reg  [15:0] cmd_dose = 16'h00c8;
   wire [6:0]  level;
   wire [15:0] dose;
   reg         self_fault = 1'b0;
   wire        relay1_out_q;
   wire        relay2_out_q;
   wire        warning_q;
   integer     fail_count = 0;
   integer     n_compared = 0;
   reg  [31:0] rd_q;
   integer     i;
   integer     f;

   always #10 sys_clk = ~sys_clk;

   rls_limit #(.TICK_CYCLES(TICK)) DUT (
      .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .normalised_level_value(level), .dose_rate(dose), .self_fault(self_fault),
      .relay1_out_q(relay1_out_q), .relay2_out_q(relay2_out_q), .warning_q(warning_q)
   );
   rls_plant_model u_plant (
      .sys_clk(sys_clk), .rst(rst), .cmd_level(cmd_level), .cmd_dose(cmd_dose),
      .level_q(level), .dose_q(dose)
   );

   task complete_run;
      begin
         $display("compared %0d mismatches %0d", n_compared, fail_count);
         if (fail_count == 0 && n_compared > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task chk(input [31:0] s, input [31:0] e);
      begin
         n_compared = n_compared + 1;
         if (s !== e) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t seen %h expected %h", $time, s, e);
         end
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge sys_clk);
   endtask
   // holds the request until waitrequest is sampled low
   task bus(input w, input [5:0] a, input [31:0] d, input [3:0] be);
      integer n;
      begin
         avs_address <= a;
         avs_writedata <= d;
         avs_byteenable <= be;
         avs_write <= w;
         avs_read <= !w;
         n = 0;
         @(posedge sys_clk);
         while (avs_waitrequest !== 1'b0 && n < 40) begin
            @(posedge sys_clk);
            n = n + 1;
         end
         rd_q = avs_readdata;
         avs_write <= 1'b0;
         avs_read <= 1'b0;
         if (n == 40) begin
            fail_count = fail_count + 1;
            complete_run;
         end
         @(posedge sys_clk);
      end
   endtask
   task wr(input [5:0] a, input [31:0] d);
      bus(1'b1, a, d, 4'h1);
   endtask
   task rdc(input [5:0] a, input [31:0] e);
      begin
         bus(1'b0, a, 32'h0, 4'hf);
         chk(rd_q, e);
      end
   endtask

   task t_defaults;
      begin
         rdc(`RLS_OFF_INTEG, 32'h7);
         rdc(`RLS_OFF_R1_ON, 32'h48);
         rdc(`RLS_OFF_R1_OFF, 32'h26);
         rdc(`RLS_OFF_R2_ON, 32'h26);
         rdc(`RLS_OFF_R2_OFF, 32'h48);
         rdc(`RLS_OFF_R1_MODE, 32'h0);
         rdc(6'h30, 32'h0);
         avs_read <= 1'b1;
         avs_write <= 1'b1;
         cyc(4);
         chk(32'(avs_waitrequest), 32'h1);
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         cyc(1);
         $display("defaults test done");
      end
   endtask
   // dose boundary at 1000 with integration 7; band and hysteresis warnings
   task t_dose;
      begin
         cmd_dose <= 16'h008e;
         cyc(4);
         rdc(`RLS_OFF_STATUS, 32'h40);
         chk(32'(warning_q), 32'h1);
         cmd_dose <= 16'h008f;
         wr(`RLS_OFF_R1_ON, 32'h5f);
         rdc(`RLS_OFF_STATUS, 32'h04);
         wr(`RLS_OFF_R1_MODE, 32'h0);
         rdc(`RLS_OFF_R1_ON, 32'h48);
         wr(`RLS_OFF_R2_OFF, 32'h39);
         rdc(`RLS_OFF_STATUS, 32'h20);
         wr(`RLS_OFF_R2_MODE, 32'h0);
         rdc(`RLS_OFF_STATUS, 32'h00);
         chk(32'(warning_q), 32'h0);
         $display("plausibility test done");
      end
   endtask
   // levels 50,38,50,72,50,38 against min relay 1 and max relay 2
   task t_relays;
      reg [41:0] lv;
      reg [5:0]  e1;
      reg [5:0]  e2;
      begin
         lv = {7'h32, 7'h26, 7'h32, 7'h48, 7'h32, 7'h26};
         e1 = 6'b000110;
         e2 = 6'b011001;
         // integration of 2 ticks; the register takes shorter settings as well
         bus(1'b1, `RLS_OFF_INTEG, 32'h2, 4'h3);
         for (i = 0; i < 6; i = i + 1) begin
            cmd_level <= lv[41 - 7 * i -: 7];
            cyc(12);
            chk(32'(relay1_out_q), 32'(e1[5 - i]));
            chk(32'(relay2_out_q), 32'(e2[5 - i]));
         end
         $display("relay switching test done");
      end
   endtask
   task t_ack;
      begin
         wr(`RLS_OFF_R1_MODE, 32'h1);
         cmd_level <= 7'h48;
         cyc(12);
         chk(32'(relay1_out_q), 32'h1);
         rdc(`RLS_OFF_R1_ACK, 32'h1);
         cmd_level <= 7'h26;
         cyc(14);
         chk(32'(relay1_out_q), 32'h1);
         wr(`RLS_OFF_R1_ACK, 32'h1);
         cyc(14);
         chk(32'(relay1_out_q), 32'h0);
         wr(`RLS_OFF_R1_MODE, 32'h0);
         $display("acknowledge test done");
      end
   endtask
   // relay 1 freezes energised, relay 2 is forced off while level moves
   task t_fault;
      begin
         wr(`RLS_OFF_R1_MODE, 32'h2);
         cmd_level <= 7'h48;
         cyc(12);
         self_fault <= 1'b1;
         cyc(10);
         cmd_level <= 7'h26;
         cyc(14);
         chk(32'(relay1_out_q), 32'h1);
         chk(32'(relay2_out_q), 32'h0);
         bus(1'b0, `RLS_OFF_STATUS, 32'h0, 4'hf);
         chk(32'(rd_q[`RLS_ST_FAULT]), 32'h1);
         self_fault <= 1'b0;
         cyc(16);
         chk(32'(relay1_out_q), 32'h0);
         chk(32'(relay2_out_q), 32'h1);
         $display("fault test done");
      end
   endtask
   task t_pulse;
      begin
         wr(`RLS_OFF_CTRL, 32'h1);
         wr(`RLS_OFF_R1_MODE, 32'h0);
         wr(`RLS_OFF_R2_MODE, 32'h0);
         rdc(`RLS_OFF_R1_ON, 32'h5a);
         rdc(`RLS_OFF_R1_OFF, 32'h0a);
         rdc(`RLS_OFF_R2_ON, 32'h0a);
         rdc(`RLS_OFF_R2_OFF, 32'h5a);
         wr(`RLS_OFF_R1_ON, 32'h37);
         bus(1'b0, `RLS_OFF_STATUS, 32'h0, 4'hf);
         chk(32'(rd_q[`RLS_ST_HYS1]), 32'h0);
         wr(`RLS_OFF_R1_ON, 32'h36);
         bus(1'b0, `RLS_OFF_STATUS, 32'h0, 4'hf);
         chk(32'(rd_q[`RLS_ST_HYS1]), 32'h1);
         chk(32'(warning_q), 32'h1);
         wr(`RLS_OFF_R1_MODE, 32'h0);
         // whole-number factors 3 and 9, the second clamps to 6
         for (i = 0; i < 2; i = i + 1) begin
            f = (i == 0) ? 3 : 6;
            bus(1'b1, `RLS_OFF_INTEG, (i == 0) ? 32'h3 : 32'h9, 4'h3);
            cmd_level <= 7'h5f;
            cyc((f - 1) * TICK);
            chk(32'(relay1_out_q), 32'h0);
            cyc(TICK + 6);
            chk(32'(relay1_out_q), 32'h1);
            chk(32'(relay2_out_q), 32'h0);
            cmd_level <= 7'h05;
            cyc(f * TICK + 6);
            chk(32'(relay1_out_q), 32'h0);
         end
         $display("pulse-count test done");
      end
   endtask

   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_defaults;
      t_dose;
      t_relays;
      t_ack;
      t_fault;
      t_pulse;
      complete_run;
   end
endmodule
